/* core/data_tenure_termination.sv */
// data tenure termination logic for the processor side of a split bus
//
// How it works
// - no beat retry input; always no-retry variant
// - retry beats bus error in same cycle
// - retry for current tenure ends it immediately
// - bus error ends tenure, later acknowledges ignored
// - beats acknowledged before error still delivered
// - error: machine check if enabled, else checkstop
// - busy negated one cycle after final termination
// - burst ends after four acknowledges
// - pipeline stalls when acknowledge is negated
// - no failing address captured; pointer is next
// - write-first qualifier runs next write first
// - writes kept in order, except a retried write rejoins at the queue tail
// - qualifier without pending read changes nothing
// - qualifier with no write runs next read
// - busy asserted cycle after qualified grant
// - up to six tenures queued
`timescale 1ns/1ps
module data_tenure_termination (
  input  wire logic                       clock_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       ce_i,
  // tenure request queue (from address side)
  input  wire logic                       enq_valid_i,
  output logic                            enq_ready_o,
  input  wire logic                       enq_write_i,
  input  wire logic                       enq_burst_i,
  input  wire logic [dtt_pkg::TAG_W-1:0]  enq_tag_i,
  // address retry for a given tenure tag
  input  wire logic                       address_retry_i,
  input  wire logic [dtt_pkg::TAG_W-1:0]  retry_tag_i,
  // system bus termination and grant; no beat retry input
  input  wire logic                       data_bus_grant_n_i,
  input  wire logic                       write_first_qualifier_n_i,
  input  wire logic                       beat_acknowledge_n_i,
  input  wire logic                       bus_error_acknowledge_n_i,
  input  wire logic [dtt_pkg::DATA_W-1:0] bus_data_i,
  output logic                            data_bus_busy_n_o,
  output logic                            data_bus_busy_oe_n_o,
  // processor state
  input  wire logic                       machine_check_enable_i,
  input  wire logic [31:0]                next_instr_pointer_i,
  output logic                            machine_check_o,
  output logic                            checkstop_o,
  output logic [31:0]                     exception_return_pointer_o,
  // tenure completion report
  output logic                            done_o,
  output logic                            done_retried_o,
  output logic                            done_error_o,
  output logic [dtt_pkg::TAG_W-1:0]       done_tag_o,
  output logic                            write_beat_o,
  // read beat data towards cache and register file
  output logic                            rd_valid_o,
  input  wire logic                       rd_ready_i,
  output logic [dtt_pkg::DATA_W-1:0]      rd_data_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [dtt_pkg::QUEUE_DEPTH-1:0]   q_write;   // entry is a write
  logic [dtt_pkg::QUEUE_DEPTH-1:0]   q_burst;   // entry is a burst
  logic [dtt_pkg::TAG_W-1:0]         q_tag [dtt_pkg::QUEUE_DEPTH];  // entry tags
  logic [2:0]                        q_count;   // entries held
  dtt_pkg::tenure_state_e            state;     // tenure state
  logic [2:0]                        beats;     // beats acknowledged
  logic [2:0]                        beat_goal; // beats in active tenure
  logic                              act_write; // active tenure is write
  logic [dtt_pkg::TAG_W-1:0]         act_tag;   // active tenure tag
  logic [dtt_pkg::QPTR_W-1:0]        pick;      // queue slot chosen
  logic                              any_write; // a write is queued
  logic                              qgrant;    // qualified grant
  logic                              master;    // we own the data bus
  logic                              ack;       // beat acknowledge taken
  logic                              err;       // error taken
  logic                              art;       // retry of active tenure
  logic                              last_beat; // final acknowledge
  logic                              finish;    // tenure ends this cycle
  logic                              deq;       // slot leaves queue
  logic                              fifo_ready;// read buffer has room
  logic                              fifo_in;   // read beat to buffer

  // oldest write slot, or slot 0 when none
  function automatic logic [dtt_pkg::QPTR_W-1:0] first_write(
    input logic [dtt_pkg::QUEUE_DEPTH-1:0] wr,
    input logic [2:0]                      cnt
  );
    logic [dtt_pkg::QPTR_W-1:0] idx;
    idx = '0;
    for (int i = dtt_pkg::QUEUE_DEPTH - 1; i >= 0; i--) begin
      if (wr[i] && (3'(i) < cnt)) begin
        idx = dtt_pkg::QPTR_W'(i);
      end
    end
    return idx;
  endfunction : first_write

  ////////////////////////////////////////////////////////////////////////////
  // selection and termination decode

  // write-first picks oldest write, else head
  always_comb begin
    any_write = 1'b0;
    for (int i = 0; i < dtt_pkg::QUEUE_DEPTH; i++) begin
      any_write = any_write | (q_write[i] && (3'(i) < q_count));
    end
    pick = (!write_first_qualifier_n_i && any_write) ? first_write(q_write, q_count) : '0;
  end

  // grant qualified only when idle with work; not in gap cycle
  assign qgrant    = (state == dtt_pkg::ST_IDLE) && !data_bus_grant_n_i && (q_count != dtt_pkg::QCOUNT_ZERO)
                     && !(address_retry_i && (retry_tag_i == q_tag[pick]));
  assign master    = (state == dtt_pkg::ST_ACTIVE);
  // terminations only count while master
  assign art       = master && address_retry_i && (retry_tag_i == act_tag);
  assign err       = master && !bus_error_acknowledge_n_i && !art;
  // stall pipeline on wait states or full buffer
  assign ack       = master && !beat_acknowledge_n_i && !art && !err && (act_write || fifo_ready);
  assign last_beat = ack && ((beats + dtt_pkg::BEAT_ONE) == beat_goal);
  assign finish    = art || err || last_beat;
  assign deq       = qgrant;
  assign fifo_in   = ack && !act_write;  // earlier beats kept even if error follows

  ////////////////////////////////////////////////////////////////////////////
  // tenure queue: compacts after removal of picked slot

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q_write <= '0;
      q_burst <= '0;
      q_count <= dtt_pkg::QCOUNT_ZERO;
      enq_ready_o <= 1'b1;
      for (int i = 0; i < dtt_pkg::QUEUE_DEPTH; i++) begin
        q_tag[i] <= '0;
      end
    end else if (ce_i) begin
      // shift entries above picked slot down, then append
      logic [2:0] base;
      base = q_count;
      if (deq) begin
        for (int i = 0; i < dtt_pkg::QUEUE_DEPTH - 1; i++) begin
          if (3'(i) >= pick) begin
            q_write[i] <= q_write[i + 1];
            q_burst[i] <= q_burst[i + 1];
            q_tag[i]   <= q_tag[i + 1];
          end
        end
        base = q_count - dtt_pkg::QCOUNT_ONE;
      end
      // retried tenure goes back to the queue for rerun
      if (art) begin
        q_write[base] <= act_write;
        q_burst[base] <= (beat_goal == dtt_pkg::BURST_BEATS);
        q_tag[base]   <= act_tag;
        base = base + dtt_pkg::QCOUNT_ONE;
      end else if (enq_valid_i && enq_ready_o) begin
        q_write[base] <= enq_write_i;
        q_burst[base] <= enq_burst_i;
        q_tag[base]   <= enq_tag_i;
        base = base + dtt_pkg::QCOUNT_ONE;
      end
      q_count <= base;
      enq_ready_o <= (base != dtt_pkg::QCOUNT_FULL);  // room flag kept on a flop
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tenure state machine and beat count

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state     <= dtt_pkg::ST_IDLE;
      beats     <= dtt_pkg::BEAT_ZERO;
      beat_goal <= dtt_pkg::SINGLE_BEATS;
      act_write <= 1'b0;
      act_tag   <= '0;
    end else if (ce_i) begin
      case (state)
        dtt_pkg::ST_IDLE: begin
          if (qgrant) begin  // take the bus next cycle
            state     <= dtt_pkg::ST_ACTIVE;
            beats     <= dtt_pkg::BEAT_ZERO;
            beat_goal <= q_burst[pick] ? dtt_pkg::BURST_BEATS : dtt_pkg::SINGLE_BEATS;
            act_write <= q_write[pick];
            act_tag   <= q_tag[pick];
          end
        end
        dtt_pkg::ST_ACTIVE: begin
          if (finish) begin  // one dead cycle before next grant
            state <= dtt_pkg::ST_GAP;
          end else if (ack) begin
            beats <= beats + dtt_pkg::BEAT_ONE;
          end
        end
        dtt_pkg::ST_GAP: begin
          state <= dtt_pkg::ST_IDLE;
        end
        default: begin
          state <= dtt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data bus busy pin, driven active low while master

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      data_bus_busy_n_o    <= 1'b1;
      data_bus_busy_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      if (qgrant) begin
        data_bus_busy_n_o    <= 1'b0;
        data_bus_busy_oe_n_o <= 1'b0;
      end else if (finish) begin  // negated after termination
        data_bus_busy_n_o    <= 1'b1;
        data_bus_busy_oe_n_o <= 1'b0;
      end else if (state == dtt_pkg::ST_GAP) begin
        data_bus_busy_oe_n_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exception reporting; no failing address is kept

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      machine_check_o            <= 1'b0;
      checkstop_o                <= 1'b0;
      exception_return_pointer_o <= '0;
    end else if (ce_i) begin
      machine_check_o <= err && machine_check_enable_i;
      if (err && !machine_check_enable_i) begin  // sticky until reset
        checkstop_o <= 1'b1;
      end
      if (err) begin  // next instruction, not faulting access
        exception_return_pointer_o <= next_instr_pointer_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion report and write beat strobe

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      done_o         <= 1'b0;
      done_retried_o <= 1'b0;
      done_error_o   <= 1'b0;
      done_tag_o     <= '0;
      write_beat_o   <= 1'b0;
    end else if (ce_i) begin
      done_o         <= finish && !art;
      done_retried_o <= art;
      done_error_o   <= err;
      write_beat_o   <= ack && act_write;
      if (finish) begin
        done_tag_o <= act_tag;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read beat buffer

  logic                       fifo_out_valid;  // buffer head valid
  logic [dtt_pkg::DATA_W-1:0] fifo_out_data;   // buffer head data
  logic                       fifo_pop;        // move head to output

  dtt_fifo #(
    .WIDTH (dtt_pkg::DATA_W),
    .DEPTH (dtt_pkg::FIFO_DEPTH),
    .PTR_W (dtt_pkg::FIFO_PTR_W)
  ) dtt_fifo_inst (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (fifo_in),
    .in_ready_o  (fifo_ready),
    .in_data_i   (bus_data_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  // registered output stage keeps outputs on flops
  assign fifo_pop = !rd_valid_o || rd_ready_i;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
    end else if (ce_i) begin
      if (fifo_pop) begin
        rd_valid_o <= fifo_out_valid;
        rd_data_o  <= fifo_out_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_grant;
    ce_i && qgrant;
  endsequence

  AST_BUSY_AFTER_GRANT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_grant |=> !data_bus_busy_n_o) else $error("busy not asserted after grant");
  AST_BUSY_NEG_END: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && finish) |=> data_bus_busy_n_o) else $error("busy not negated at end");
  AST_RETRY_OVER_ERROR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && art) |=> !done_error_o && done_retried_o) else $error("error not ignored on retry");
  AST_ERR_ENDS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && err) |=> (state == dtt_pkg::ST_GAP) && !write_beat_o) else $error("error did not end tenure");
  AST_MCHK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && err && machine_check_enable_i) |=> machine_check_o && !checkstop_o)
    else $error("machine check missing");
  AST_CHKSTOP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && err && !machine_check_enable_i) |=> checkstop_o) else $error("checkstop missing");
  AST_NO_ACK_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && state == dtt_pkg::ST_IDLE) |=> !write_beat_o && !done_o && !done_error_o && !machine_check_o)
    else $error("termination taken while not master");
  AST_BURST_FOUR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (last_beat && beat_goal == dtt_pkg::BURST_BEATS) |-> beats == 3'h3) else $error("burst count wrong");
  AST_STALL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && master && beat_acknowledge_n_i && !finish) |=> $stable(beats)) else $error("pipeline advanced");
  AST_QUEUE_MAX: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    q_count <= dtt_pkg::QCOUNT_FULL) else $error("queue overflow");

endmodule : data_tenure_termination

/* core/dtt_fifo.sv */
// parameterised valid/ready fifo for read beat data
`timescale 1ns/1ps
module dtt_fifo #(
  parameter int unsigned WIDTH = 64,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned PTR_W = 4
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];  // storage words
  logic [PTR_W:0]   wr_ptr;       // write pointer with wrap bit
  logic [PTR_W:0]   rd_ptr;       // read pointer with wrap bit
  logic             push;         // word accepted
  logic             pop;          // word drained

  assign push        = ce_i && in_valid_i && in_ready_o;
  assign pop         = ce_i && out_valid_o && out_ready_i;
  // full when pointers differ only in wrap bit
  assign in_ready_o  = !((wr_ptr[PTR_W] != rd_ptr[PTR_W]) && (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]));
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o  = mem[rd_ptr[PTR_W-1:0]];

  // storage write
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr[PTR_W-1:0]] <= in_data_i;
    end
  end

  // pointer update
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : dtt_fifo

/* core/dtt_pkg.sv */
// shared constants for the data tenure termination block
package dtt_pkg;
  localparam int unsigned QUEUE_DEPTH  = 6;     // pending data tenures held
  localparam int unsigned QPTR_W       = 3;     // width of queue index
  localparam int unsigned TAG_W        = 4;     // tenure tag width
  localparam int unsigned DATA_W       = 64;    // data bus width
  localparam int unsigned BEAT_W       = 3;     // beat counter width
  localparam logic [2:0]  BURST_BEATS  = 3'h4;  // beats in a burst
  localparam logic [2:0]  SINGLE_BEATS = 3'h1;  // beats in a single transfer
  localparam int unsigned FIFO_DEPTH   = 16;    // read data buffer depth
  localparam int unsigned FIFO_PTR_W   = 4;     // buffer pointer width
  localparam logic [2:0]  QCOUNT_ZERO  = 3'h0;  // empty queue count
  localparam logic [2:0]  QCOUNT_FULL  = 3'h6;  // full queue count
  localparam logic [2:0]  QCOUNT_ONE   = 3'h1;  // unit step for counts
  localparam logic [2:0]  BEAT_ZERO    = 3'h0;  // beat count reset value
  localparam logic [2:0]  BEAT_ONE     = 3'h1;  // unit beat step
  // data tenure state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_GAP
  } tenure_state_e;
endpackage : dtt_pkg

/* dv/data_tenure_termination_bench.sv */
// self-checking bench for the data tenure termination block
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module data_tenure_termination_bench;
  logic clock_i, rst_n_i, enq_valid_i, enq_write_i, enq_burst_i, address_retry_i, rd_ready_i;
  logic data_bus_grant_n_i, write_first_qualifier_n_i, machine_check_enable_i;
  logic beat_acknowledge_n_i, bus_error_acknowledge_n_i, enq_ready_o, data_bus_busy_n_o;
  logic data_bus_busy_oe_n_o, machine_check_o, checkstop_o, done_o, done_retried_o;
  logic done_error_o, write_beat_o, rd_valid_o, start, stray, ce;
  logic [3:0] enq_tag_i, retry_tag_i, done_tag_o;
  logic [31:0] next_instr_pointer_i, exception_return_pointer_o;
  logic [63:0] rd_data_o, bus_data_i;
  logic [2:0] beats, err_beat;
  logic [1:0] wait_n;
  logic [7:0] base;
  int errors, checks, cycles, wbeats, mcount, dcount;
  logic [63:0] got[$];  // read words seen
  logic [63:0] want[$]; // read words expected
  ////////////////////////////////////////////////////////////////
  data_tenure_termination data_tenure_termination_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce), .enq_valid_i(enq_valid_i),
    .enq_ready_o(enq_ready_o), .enq_write_i(enq_write_i), .enq_burst_i(enq_burst_i),
    .enq_tag_i(enq_tag_i), .address_retry_i(address_retry_i), .retry_tag_i(retry_tag_i),
    .data_bus_grant_n_i(data_bus_grant_n_i), .write_first_qualifier_n_i(write_first_qualifier_n_i),
    .beat_acknowledge_n_i(beat_acknowledge_n_i), .bus_error_acknowledge_n_i(bus_error_acknowledge_n_i),
    .bus_data_i(bus_data_i), .data_bus_busy_n_o(data_bus_busy_n_o),
    .data_bus_busy_oe_n_o(data_bus_busy_oe_n_o), .machine_check_enable_i(machine_check_enable_i),
    .next_instr_pointer_i(next_instr_pointer_i), .machine_check_o(machine_check_o),
    .checkstop_o(checkstop_o), .exception_return_pointer_o(exception_return_pointer_o),
    .done_o(done_o), .done_retried_o(done_retried_o), .done_error_o(done_error_o),
    .done_tag_o(done_tag_o), .write_beat_o(write_beat_o), .rd_valid_o(rd_valid_o),
    .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o));
  dtt_slave_model dtt_slave_model_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .busy_n_i(data_bus_busy_n_o), .start_i(start),
    .beats_i(beats), .wait_i(wait_n), .err_beat_i(err_beat), .base_i(base), .stray_i(stray),
    .ack_n_o(beat_acknowledge_n_i), .err_n_o(bus_error_acknowledge_n_i), .data_o(bus_data_i));
  ////////////////////////////////////////////////////////////////
  // clock at 125 MHz
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // collects read words, counts pulses, cuts a hang short
  always @(posedge clock_i) begin
    cycles++;
    if (rd_valid_o && rd_ready_i) got.push_back(rd_data_o);
    if (write_beat_o) wbeats++;
    if (machine_check_o) mcount++;
    if (done_o) dcount++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////
  task complete_run;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // offers one tenure to the queue
  task enq(input logic w, input logic b, input logic [3:0] t);
    @(negedge clock_i);
    {enq_valid_i, enq_write_i, enq_burst_i, enq_tag_i} = {1'b1, w, b, t};
    @(posedge clock_i);
    @(negedge clock_i);
    enq_valid_i = 1'b0;
  endtask : enq
  // arbiter grants the bus and primes the slave
  task grant(input logic wf, input logic [2:0] n, input logic [1:0] w, input logic [2:0] e,
             input logic [7:0] bs);
    repeat (3) @(negedge clock_i);
    data_bus_grant_n_i = 1'b0;
    write_first_qualifier_n_i = ~wf;
    {start, beats, wait_n, err_beat, base} <= {1'b1, n, w, e, bs};
    @(posedge clock_i);
    #1;
    `CHK("busy_n", 1'b0, data_bus_busy_n_o)
    `CHK("busy_oe_n", 1'b0, data_bus_busy_oe_n_o)
    @(negedge clock_i);
    {data_bus_grant_n_i, write_first_qualifier_n_i} = 2'b11;
    start <= 1'b0;
  endtask : grant
  // waits for the end of a tenure and judges how it ended
  task wait_end(input logic [3:0] t, input logic e, input logic r);
    for (int k = 0; k < 60 && !(done_o || done_retried_o); k++) begin
      @(posedge clock_i);
      #1;
    end
    `CHK("done seen", 1'b1, done_o || done_retried_o)
    `CHK("done_tag", t, done_tag_o)
    `CHK("done_error", e, done_error_o)
    `CHK("done_retried", r, done_retried_o)
    `CHK("busy_n end", 1'b1, data_bus_busy_n_o)
    @(posedge clock_i);
    #1;
    `CHK("busy_oe_n end", 1'b1, data_bus_busy_oe_n_o)
  endtask : wait_end
  // compares read words after the buffer drains
  task chk_rd;
    repeat (24) @(posedge clock_i);
    `CHK("rd_count", want.size(), got.size())
    foreach (want[i]) `CHK("rd_data", want[i], got[i])
    want.delete();
    got.delete();
  endtask : chk_rd
  ////////////////////////////////////////////////////////////////
  task t_single_and_burst;
    enq(1'b0, 1'b0, 4'h1);
    grant(1'b0, 3'h1, 2'h0, 3'h0, 8'h11);
    want.push_back({8'h11, 53'h0, 3'h0});
    wait_end(4'h1, 1'b0, 1'b0);
    enq(1'b0, 1'b1, 4'h2);
    grant(1'b0, 3'h4, 2'h2, 3'h0, 8'h22);
    for (int i = 0; i < 4; i++) want.push_back({8'h22, 53'h0, 3'(i)});
    wait_end(4'h2, 1'b0, 1'b0);
    chk_rd();
    $display("test single and burst done");
  endtask : t_single_and_burst
  task t_error;
    int d;
    @(negedge clock_i);
    machine_check_enable_i = 1'b1;
    next_instr_pointer_i = 32'h0000_1230;
    enq(1'b0, 1'b1, 4'h3);
    grant(1'b0, 3'h4, 2'h0, 3'h3, 8'h33);
    for (int i = 0; i < 2; i++) want.push_back({8'h33, 53'h0, 3'(i)});
    wait_end(4'h3, 1'b1, 1'b0);
    d = dcount;
    @(negedge clock_i);
    stray <= 1'b1;
    repeat (3) @(negedge clock_i);
    stray <= 1'b0;
    chk_rd();
    `CHK("done count", d, dcount)
    `CHK("mcheck", 1, mcount)
    `CHK("return ptr", 32'h0000_1230, exception_return_pointer_o)
    $display("test bus error done");
  endtask : t_error
  task t_retry;
    enq(1'b0, 1'b0, 4'h7);
    grant(1'b0, 3'h1, 2'h0, 3'h1, 8'h44);
    @(negedge clock_i);
    {address_retry_i, retry_tag_i} = {1'b1, 4'h7};
    @(negedge clock_i);
    address_retry_i = 1'b0;
    wait_end(4'h7, 1'b0, 1'b1);
    grant(1'b0, 3'h1, 2'h0, 3'h0, 8'h45);
    want.push_back({8'h45, 53'h0, 3'h0});
    wait_end(4'h7, 1'b0, 1'b0);
    chk_rd();
    `CHK("mcheck", 1, mcount)
    $display("test retry done");
  endtask : t_retry
  task t_write_first;
    enq(1'b0, 1'b0, 4'h8);
    enq(1'b1, 1'b1, 4'h9);
    enq(1'b1, 1'b0, 4'ha);
    wbeats = 0;
    grant(1'b1, 3'h4, 2'h1, 3'h0, 8'h55);
    wait_end(4'h9, 1'b0, 1'b0);
    `CHK("write beats", 4, wbeats)
    grant(1'b1, 3'h1, 2'h0, 3'h0, 8'h56);
    wait_end(4'ha, 1'b0, 1'b0);
    grant(1'b1, 3'h1, 2'h0, 3'h0, 8'h57);
    want.push_back({8'h57, 53'h0, 3'h0});
    wait_end(4'h8, 1'b0, 1'b0);
    chk_rd();
    enq(1'b1, 1'b0, 4'hb);
    enq(1'b1, 1'b0, 4'hc);
    grant(1'b1, 3'h1, 2'h0, 3'h0, 8'h58);
    wait_end(4'hb, 1'b0, 1'b0);
    grant(1'b0, 3'h1, 2'h0, 3'h0, 8'h59);
    wait_end(4'hc, 1'b0, 1'b0);
    $display("test write first done");
  endtask : t_write_first
  task t_fill;
    @(negedge clock_i);
    rd_ready_i = 1'b0;
    for (int i = 0; i < 6; i++) enq(1'b0, i < 4, 4'(i));
    `CHK("enq_ready full", 1'b0, enq_ready_o)
    for (int i = 0; i < 6; i++) begin
      if (i == 4) begin
        @(negedge clock_i);
        rd_ready_i = 1'b1;
      end
      grant(1'b0, i < 4 ? 3'h4 : 3'h1, 2'h0, 3'h0, 8'(i));
      for (int b = 0; b < (i < 4 ? 4 : 1); b++) want.push_back({8'(i), 53'h0, 3'(b)});
      wait_end(4'(i), 1'b0, 1'b0);
    end
    chk_rd();
    $display("test fill done");
  endtask : t_fill
  task t_checkstop;
    @(negedge clock_i);
    machine_check_enable_i = 1'b0;
    enq(1'b1, 1'b0, 4'hd);
    grant(1'b0, 3'h1, 2'h0, 3'h1, 8'h66);
    wait_end(4'hd, 1'b1, 1'b0);
    `CHK("checkstop", 1'b1, checkstop_o)
    `CHK("mcheck", 1, mcount)
    $display("test checkstop done");
  endtask : t_checkstop
  // clock enable low: a grant must not be taken
  task t_freeze;
    enq(1'b0, 1'b0, 4'he);
    @(negedge clock_i);
    {ce, data_bus_grant_n_i} = 2'b00;
    repeat (3) @(negedge clock_i);
    `CHK("frozen busy_n", 1'b1, data_bus_busy_n_o)
    {ce, data_bus_grant_n_i} = 2'b11;
    grant(1'b0, 3'h1, 2'h0, 3'h0, 8'h77);
    want.push_back({8'h77, 53'h0, 3'h0});
    wait_end(4'he, 1'b0, 1'b0);
    chk_rd();
    $display("test freeze done");
  endtask : t_freeze
  ////////////////////////////////////////////////////////////////
  // reset, then the scenarios in turn
  initial begin
    {rst_n_i, enq_valid_i, enq_write_i, enq_burst_i, address_retry_i, stray, start} = 7'h0;
    {data_bus_grant_n_i, write_first_qualifier_n_i, rd_ready_i, ce} = 4'hf;
    {enq_tag_i, retry_tag_i, beats, wait_n, err_beat, base} = 24'h0;
    {machine_check_enable_i, next_instr_pointer_i} = 33'h0;
    repeat (5) @(negedge clock_i);
    rst_n_i = 1'b1;
    `CHK("reset busy_n", 1'b1, data_bus_busy_n_o)
    `CHK("reset enq_ready", 1'b1, enq_ready_o)
    t_single_and_burst();
    t_error();
    t_retry();
    t_write_first();
    t_fill();
    t_checkstop();
    t_freeze();
    complete_run();
  end
endmodule : data_tenure_termination_bench

/* dv/dtt_slave_model.sv */
// slave responder model: beat acknowledge, wait states and bus error
`timescale 1ns/1ps
module dtt_slave_model (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        busy_n_i,
  input  wire logic        start_i,
  input  wire logic [2:0]  beats_i,
  input  wire logic [1:0]  wait_i,
  input  wire logic [2:0]  err_beat_i,
  input  wire logic [7:0]  base_i,
  input  wire logic        stray_i,
  output logic             ack_n_o,
  output logic             err_n_o,
  output logic      [63:0] data_o
);
  logic [2:0] left;   // beats still owed
  logic [2:0] nbeat;  // beats already given
  logic [1:0] wcnt;   // wait states spent before this beat
  ////////////////////////////////////////////////////////////////
  // drives on the falling edge so levels are settled at the rising one
  always @(negedge clock_i) begin
    ack_n_o <= ~stray_i;  // idle: high unless a stray pulse is asked
    err_n_o <= ~stray_i;
    data_o  <= ~data_o;   // released lines change every cycle
    if (!rst_n_i) begin
      left   <= 3'h0;
      data_o <= 64'h0;
    end else if (start_i) begin
      left  <= beats_i;
      nbeat <= 3'h0;
      wcnt  <= 2'h0;
    end else if (!busy_n_i && left != 3'h0) begin
      if (wcnt != wait_i) begin
        wcnt <= wcnt + 2'h1;
      end else if (nbeat + 3'h1 == err_beat_i) begin
        err_n_o <= 1'b0;  // fatal end only
        left    <= 3'h0;
      end else begin
        ack_n_o <= 1'b0;  // data valid with acknowledge
        data_o  <= {base_i, 53'h0, nbeat};
        left    <= left - 3'h1;
        nbeat   <= nbeat + 3'h1;
        wcnt    <= 2'h0;
      end
    end
  end
endmodule : dtt_slave_model
